// *** pkg/afecs_pkg.sv ***
// constants, register map and carriers for the command and sample-start block
package afecs_pkg;

    localparam int          CLK_HZ          = 40_000_000;
    localparam int          TB_RATE_HZ      = 4_000_000;
    localparam logic [3:0]  TB_DIV_LAST     = 4'(CLK_HZ / TB_RATE_HZ - 1);

    localparam int          FAULT_FLAG_REGISTER_TIME_US    = 16_000;
    localparam int          FAULT_FLAG_REGISTER_CW         = 20;
    localparam logic [19:0] FAULT_FLAG_REGISTER_CYCLES_DEF = 20'(FAULT_FLAG_REGISTER_TIME_US * (CLK_HZ / 1_000_000));

    localparam int          SPI_ADDR_BITS   = 8;
    localparam int          SPI_DATA_BITS   = 24;
    localparam int          SPI_FRAME_BITS  = SPI_ADDR_BITS + SPI_DATA_BITS;
    localparam logic [5:0]  SPI_ADDR_LAST   = 6'(SPI_ADDR_BITS - 1);
    localparam logic [5:0]  SPI_FRAME_LAST  = 6'(SPI_FRAME_BITS - 1);
    localparam logic [5:0]  SPI_DATA_FIRST  = 6'(SPI_ADDR_BITS);

    localparam logic [7:0]  ADDR_COMMAND    = 8'h00;
    localparam logic [7:0]  ADDR_START_CNT  = 8'h01;
    localparam logic [7:0]  ADDR_FAULT_FLAG = 8'h30;

    localparam int          SOFT_RESET_BIT  = 3;
    localparam int          FAULT_CHECK_BIT = 2;
    localparam int          TB_HOLD_BIT     = 1;
    localparam int          READBACK_BIT    = 0;

    localparam int          COUNT_W         = 16;
    localparam int          FLAG_W          = 13;
    localparam logic [15:0] START_CNT_RST   = 16'h0000;
    localparam logic [12:0] FLAGS_RST       = 13'h0000;
    localparam logic [23:0] WORD_ZERO       = 24'h000000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [23:0] data;
    } afecs_frame_s;

endpackage

// *** design/afecs_spi_port.sv ***
// serial host port: pin synchronisers, frame receive and readback shift-out
`timescale 1ns/1ps
module afecs_spi_port
    import afecs_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         spi_sclk,
    input  wire logic         spi_cs_n,
    input  wire logic         spi_mosi,
    input  wire logic [23:0]  rd_word,
    output logic              spi_miso,
    output logic              spi_miso_oe,
    output logic              addr_done,
    output logic [7:0]        addr_seen,
    output logic              frame_valid,
    output afecs_frame_s      frame
);

    logic [2:0]   sclk_sy_r;
    logic [2:0]   cs_sy_r;
    logic [2:0]   mosi_sy_r;
    logic         sclk_l_r,  sclk_l_nxt;
    logic         cs_l_r,    cs_l_nxt;
    logic         mosi_l_r,  mosi_l_nxt;
    logic [5:0]   bit_cnt_r, bit_cnt_nxt;
    logic [31:0]  shin_r,    shin_nxt;
    logic [23:0]  shout_r,   shout_nxt;
    logic         oe_r,      oe_nxt;
    logic         adone_r,   adone_nxt;
    logic         fvalid_r,  fvalid_nxt;
    logic [7:0]   aseen_r,   aseen_nxt;
    afecs_frame_s frame_r,   frame_nxt;
    logic         rise;
    logic         fall;

    always_comb
    begin
        // a level counts only once the second and third stages agree
        sclk_l_nxt  = (sclk_sy_r[1] == sclk_sy_r[2]) ? sclk_sy_r[2] : sclk_l_r;
        cs_l_nxt    = (cs_sy_r[1] == cs_sy_r[2]) ? cs_sy_r[2] : cs_l_r;
        mosi_l_nxt  = (mosi_sy_r[1] == mosi_sy_r[2]) ? mosi_sy_r[2] : mosi_l_r;
        rise        = sclk_l_nxt & ~sclk_l_r;
        fall        = ~sclk_l_nxt & sclk_l_r;
        bit_cnt_nxt = bit_cnt_r;
        shin_nxt    = shin_r;
        shout_nxt   = shout_r;
        adone_nxt   = 1'b0;
        fvalid_nxt  = 1'b0;
        aseen_nxt   = aseen_r;
        frame_nxt   = frame_r;
        oe_nxt      = ~cs_l_r;
        if (cs_l_r)
        begin
            bit_cnt_nxt = 6'h00;
            shout_nxt   = WORD_ZERO;
        end
        else if (rise)
        begin
            shin_nxt    = {shin_r[30:0], mosi_l_r};
            bit_cnt_nxt = (bit_cnt_r == SPI_FRAME_LAST) ? 6'h00 : bit_cnt_r + 6'h01;
            if (bit_cnt_r == SPI_ADDR_LAST)
            begin
                adone_nxt = 1'b1;
                aseen_nxt = {shin_r[6:0], mosi_l_r};
            end
            if (bit_cnt_r == SPI_FRAME_LAST)
            begin
                fvalid_nxt = 1'b1;
                frame_nxt  = {shin_r[30:0], mosi_l_r};
            end
        end
        else if (fall)
        begin
            // sclk must be slow enough that rd_word settles before this edge
            shout_nxt = (bit_cnt_r == SPI_DATA_FIRST) ? rd_word : {shout_r[22:0], 1'b0};
        end
    end

    always_ff @(posedge clock)
    begin
        sclk_sy_r <= {sclk_sy_r[1:0], spi_sclk};
        cs_sy_r   <= {cs_sy_r[1:0], spi_cs_n};
        mosi_sy_r <= {mosi_sy_r[1:0], spi_mosi};
        if (rst)
        begin
            sclk_l_r  <= 1'b0;
            cs_l_r    <= 1'b1;
            mosi_l_r  <= 1'b0;
            bit_cnt_r <= 6'h00;
            shin_r    <= 32'h00000000;
            shout_r   <= WORD_ZERO;
            oe_r      <= 1'b0;
            adone_r   <= 1'b0;
            fvalid_r  <= 1'b0;
            aseen_r   <= 8'h00;
            frame_r   <= '0;
        end
        else
        begin
            sclk_l_r  <= sclk_l_nxt;
            cs_l_r    <= cs_l_nxt;
            mosi_l_r  <= mosi_l_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shin_r    <= shin_nxt;
            shout_r   <= shout_nxt;
            oe_r      <= oe_nxt;
            adone_r   <= adone_nxt;
            fvalid_r  <= fvalid_nxt;
            aseen_r   <= aseen_nxt;
            frame_r   <= frame_nxt;
        end
    end

    assign spi_miso    = shout_r[23];
    assign spi_miso_oe = oe_r;
    assign addr_done   = adone_r;
    assign addr_seen   = aseen_r;
    assign frame_valid = fvalid_r;
    assign frame       = frame_r;

endmodule

// *** design/afecs_top.sv ***
// command register, fault-check sequencer, timebase and sample-start window
//
// Overview of operation
// - command register is write-only; reading it returns zero.
// - soft reset bit returns all internal registers to defaults, then clears.
// - writing one to fault check start begins diagnostics at once; zero does nothing.
// - at sequence end every fault result is stored in the fault flag register.
// - fault check start clears itself when the 16 ms sequence completes.
// - timebase hold keeps timing counters in reset; host clears it to run.
// - readback enable resets to zero; one enables register reads over serial port.
// - start count is 16 bits; upper eight bits are written zero.
// - sample window starts at the programmed count within the repetition period.
// - timing counts are cycles of the 4 MHz timebase.
`timescale 1ns/1ps
module afecs_top
    import afecs_pkg::*;
#(
    parameter logic [19:0] FAULT_FLAG_REGISTER_CYCLES = FAULT_FLAG_REGISTER_CYCLES_DEF
)
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         spi_sclk,
    input  wire logic         spi_cs_n,
    input  wire logic         spi_mosi,
    input  wire logic [15:0]  period_length_count,
    input  wire logic [15:0]  sample_end_count,
    input  wire logic [12:0]  fault_probe_in,
    output logic              spi_miso,
    output logic              spi_miso_oe,
    output logic              fault_check_active,
    output logic [12:0]       fault_flag_register,
    output logic              timebase_tick,
    output logic [15:0]       period_count,
    output logic              sample_window
);

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    logic                 addr_done;
    logic [7:0]           addr_seen;
    logic                 frame_valid;
    afecs_frame_s         frame;

    logic [15:0]          start_cnt_r, start_cnt_nxt;
    logic                 hold_r,      hold_nxt;
    logic                 readback_r,  readback_nxt;
    logic                 fault_flag_register_r,      fault_flag_register_nxt;
    logic [FAULT_FLAG_REGISTER_CW-1:0]   fault_flag_register_cnt_r,  fault_flag_register_cnt_nxt;
    logic [FLAG_W-1:0]    flags_r,     flags_nxt;
    logic [3:0]           div_r,       div_nxt;
    logic                 tick_r,      tick_nxt;
    logic [COUNT_W-1:0]   period_r,    period_nxt;
    logic                 window_r,    window_nxt;
    logic [23:0]          rd_word_r,   rd_word_nxt;
    logic                 wr_en;
    logic                 cmd_wr;
    logic                 soft_rst;

    afecs_spi_port u_port
    (
        .clock       (clock),
        .rst         (rst),
        .spi_sclk    (spi_sclk),
        .spi_cs_n    (spi_cs_n),
        .spi_mosi    (spi_mosi),
        .rd_word     (rd_word_r),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .addr_done   (addr_done),
        .addr_seen   (addr_seen),
        .frame_valid (frame_valid),
        .frame       (frame)
    );

    // command frames are always writes, so readback can be switched off again
    assign wr_en    = frame_valid & (addr_is(frame.addr, ADDR_COMMAND) | ~readback_r);
    assign cmd_wr   = wr_en & addr_is(frame.addr, ADDR_COMMAND);
    assign soft_rst = cmd_wr & frame.data[SOFT_RESET_BIT];

    // register file and fault-check sequencer
    always_comb
    begin
        start_cnt_nxt = start_cnt_r;
        hold_nxt      = hold_r;
        readback_nxt  = readback_r;
        fault_flag_register_nxt      = fault_flag_register_r;
        fault_flag_register_cnt_nxt  = fault_flag_register_cnt_r;
        flags_nxt     = flags_r;
        rd_word_nxt   = rd_word_r;
        if (fault_flag_register_r)
        begin
            if (fault_flag_register_cnt_r == FAULT_FLAG_REGISTER_CYCLES - 20'h00001)
            begin
                fault_flag_register_nxt  = 1'b0;
                flags_nxt = fault_probe_in;
            end
            else
            begin
                fault_flag_register_cnt_nxt = fault_flag_register_cnt_r + 20'h00001;
            end
        end
        if (cmd_wr)
        begin
            hold_nxt     = frame.data[TB_HOLD_BIT];
            readback_nxt = frame.data[READBACK_BIT];
            // a start landing on the completion cycle wins and restarts
            if (frame.data[FAULT_CHECK_BIT])
            begin
                fault_flag_register_nxt     = 1'b1;
                fault_flag_register_cnt_nxt = '0;
            end
        end
        if (wr_en && addr_is(frame.addr, ADDR_START_CNT))
        begin
            start_cnt_nxt = frame.data[COUNT_W-1:0];
        end
        if (addr_done)
        begin
            rd_word_nxt = WORD_ZERO;
            if (readback_r && addr_is(addr_seen, ADDR_START_CNT))
            begin
                rd_word_nxt = {8'h00, start_cnt_r};
            end
            else if (readback_r && addr_is(addr_seen, ADDR_FAULT_FLAG))
            begin
                rd_word_nxt = {11'h000, flags_r};
            end
        end
        if (soft_rst)
        begin
            start_cnt_nxt = START_CNT_RST;
            hold_nxt      = 1'b0;
            readback_nxt  = 1'b0;
            fault_flag_register_nxt      = 1'b0;
            fault_flag_register_cnt_nxt  = '0;
            flags_nxt     = FLAGS_RST;
            rd_word_nxt   = WORD_ZERO;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            start_cnt_r <= START_CNT_RST;
            hold_r      <= 1'b0;
            readback_r  <= 1'b0;
            fault_flag_register_r      <= 1'b0;
            fault_flag_register_cnt_r  <= '0;
            flags_r     <= FLAGS_RST;
            rd_word_r   <= WORD_ZERO;
        end
        else
        begin
            start_cnt_r <= start_cnt_nxt;
            hold_r      <= hold_nxt;
            readback_r  <= readback_nxt;
            fault_flag_register_r      <= fault_flag_register_nxt;
            fault_flag_register_cnt_r  <= fault_flag_register_cnt_nxt;
            flags_r     <= flags_nxt;
            rd_word_r   <= rd_word_nxt;
        end
    end

    // 4 MHz timebase, repetition-period counter and sample window
    always_comb
    begin
        div_nxt    = div_r;
        tick_nxt   = 1'b0;
        period_nxt = period_r;
        window_nxt = window_r;
        if (hold_r || soft_rst)
        begin
            div_nxt    = 4'h0;
            period_nxt = '0;
            window_nxt = 1'b0;
        end
        else if (div_r == TB_DIV_LAST)
        begin
            div_nxt  = 4'h0;
            tick_nxt = 1'b1;
        end
        else
        begin
            div_nxt = div_r + 4'h1;
        end
        if (tick_r && !hold_r && !soft_rst)
        begin
            period_nxt = (period_r == period_length_count) ? '0 : period_r + 16'h0001;
            // compare the count being entered so the window lines up with it
            // end wins when both match, so equal counts give no window
            if (period_nxt == sample_end_count)
            begin
                window_nxt = 1'b0;
            end
            else if (period_nxt == start_cnt_r)
            begin
                window_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            div_r    <= 4'h0;
            tick_r   <= 1'b0;
            period_r <= '0;
            window_r <= 1'b0;
        end
        else
        begin
            div_r    <= div_nxt;
            tick_r   <= tick_nxt;
            period_r <= period_nxt;
            window_r <= window_nxt;
        end
    end

    assign fault_check_active  = fault_flag_register_r;
    assign fault_flag_register = flags_r;
    assign timebase_tick       = tick_r;
    assign period_count        = period_r;
    assign sample_window       = window_r;

endmodule

// *** sim/afecs_chk.sv ***
// assertion checker for the command and sample-start block
`timescale 1ns/1ps
module afecs_chk
    import afecs_pkg::*;
#(
    parameter logic [19:0] FAULT_FLAG_REGISTER_CYCLES = FAULT_FLAG_REGISTER_CYCLES_DEF
)
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        spi_cs_n,
    input wire logic [15:0] period_length_count,
    input wire logic [15:0] sample_end_count,
    input wire logic [12:0] fault_probe_in,
    input wire logic        spi_miso,
    input wire logic        spi_miso_oe,
    input wire logic        fault_check_active,
    input wire logic [12:0] fault_flag_register,
    input wire logic        timebase_tick,
    input wire logic [15:0] period_count,
    input wire logic        sample_window
);
    logic [19:0] act_cnt_r;
    logic [19:0] act_cnt_nxt;
    logic [3:0]  gap_r;
    logic [3:0]  gap_nxt;

    // clocks since the last tick, saturating at the top
    always_comb gap_nxt = timebase_tick ? 4'h0 : gap_r + 4'(gap_r != 4'hF);
    always_ff @(posedge clock) gap_r <= rst ? 4'h0 : gap_nxt;

    // cycles spent in diagnostics so far
    always_comb act_cnt_nxt = fault_check_active ? act_cnt_r + 20'h00001 : 20'h00000;
    always_ff @(posedge clock) act_cnt_r <= rst ? 20'h00000 : act_cnt_nxt;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_quiet: assert property ($fell(rst) |-> !fault_check_active && !sample_window
        && fault_flag_register == FLAGS_RST && period_count == 16'h0000 && !spi_miso_oe)
        else $error("outputs not at defaults after reset");
    a_flag_load: assert property ($fell(fault_check_active) && act_cnt_r == FAULT_FLAG_REGISTER_CYCLES
        |-> fault_flag_register == $past(fault_probe_in))
        else $error("fault flags not loaded at sequence end");
    a_flag_stable: assert property ($changed(fault_flag_register)
        |-> $fell(fault_check_active) || fault_flag_register == FLAGS_RST)
        else $error("fault flags changed outside sequence end");
    a_fault_flag_register_bound: assert property (fault_check_active |-> act_cnt_r < FAULT_FLAG_REGISTER_CYCLES)
        else $error("diagnostics ran too long");
    a_tick_space: assert property (timebase_tick |-> gap_r >= 4'h9)
        else $error("timebase ticks closer than ten clocks");
    a_period_step: assert property ($changed(period_count) && period_count != 16'h0000
        |-> period_count == $past(period_count) + 16'h0001)
        else $error("period counter skipped");
    a_period_max: assert property (period_count <= period_length_count)
        else $error("period counter beyond period length");
    a_window_end: assert property (period_count == sample_end_count |-> !sample_window)
        else $error("sample window open at end count");
    a_miso_idle: assert property (!spi_miso_oe |-> !spi_miso)
        else $error("serial out not low while released");
    a_oe_follow: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
        else $error("serial out driven while deselected");
endmodule

bind afecs_top afecs_chk #(.FAULT_FLAG_REGISTER_CYCLES(FAULT_FLAG_REGISTER_CYCLES)) u_chk (.clock(clock), .rst(rst),
    .spi_cs_n(spi_cs_n), .period_length_count(period_length_count),
    .sample_end_count(sample_end_count), .fault_probe_in(fault_probe_in),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .fault_check_active(fault_check_active),
    .fault_flag_register(fault_flag_register), .timebase_tick(timebase_tick),
    .period_count(period_count), .sample_window(sample_window));

// *** sim/afecs_host_model.sv ***
// host-side serial port model: mode 0 frames, msb first
`timescale 1ns/1ps
module afecs_host_model
(
    input  wire logic clock,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // 5-clock phases stay above the synchroniser minimum of 4
    task automatic xfer(input logic [31:0] f, output logic [23:0] rd);
        spi_cs_n = 1'b0;
        step(4);
        for (int i = 31; i >= 0; i--)
        begin
            spi_mosi = f[i];
            step(5);
            spi_sclk = 1'b1;
            rd = {rd[22:0], spi_miso_oe ? spi_miso : 1'b0};
            step(5);
            spi_sclk = 1'b0;
        end
        step(5);
        spi_cs_n = 1'b1;
        // released data line must not keep looking valid
        spi_mosi = ~spi_mosi;
        step(10);
    endtask
endmodule

// *** sim/afecs_top_tb.sv ***
// self-checking bench for the command and sample-start block
`timescale 1ns/1ps
module afecs_top_tb;
    import afecs_pkg::*;
    localparam logic [19:0] FAULT_FLAG_REGISTER_SIM = 20'h00032;
    logic        clock;
    logic        rst;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic        fault_check_active;
    logic        timebase_tick;
    logic        sample_window;
    logic [15:0] period_length_count;
    logic [15:0] sample_end_count;
    logic [15:0] period_count;
    logic [12:0] fault_probe_in;
    logic [12:0] fault_flag_register;
    logic [23:0] rd_w;
    logic [23:0] d;
    int          miscompares;
    int          total_checks;
    int          cycles;
    int          act_len;
    int          ticks;
    int          stamp;

    afecs_top #(.FAULT_FLAG_REGISTER_CYCLES(FAULT_FLAG_REGISTER_SIM)) u_dut (.clock(clock), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .period_length_count(period_length_count),
        .sample_end_count(sample_end_count), .fault_probe_in(fault_probe_in),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .fault_check_active(fault_check_active),
        .fault_flag_register(fault_flag_register), .timebase_tick(timebase_tick),
        .period_count(period_count), .sample_window(sample_window));
    afecs_host_model u_host (.clock(clock), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

    always #12.5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        act_len += (fault_check_active === 1'b1);
        ticks += (timebase_tick === 1'b1);
        if (cycles == 40000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    function automatic logic [23:0] start_read(input logic [23:0] w);
        return {8'h00, w[15:0]};
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        u_host.xfer({a, v}, rd_w);
    endtask

    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 400 && s !== v; i++) step(1);
        check({23'h000000, s}, {23'h000000, v});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        period_length_count = 16'h0007;
        sample_end_count = 16'h0005;
        fault_probe_in = 13'h0000;
        void'($urandom(32'hB32E));
        step(4);
        rst = 1'b0;
        step(4);
        check({8'h00, period_count}, WORD_ZERO);
        wr(ADDR_START_CNT, 24'h00ABCD);
        wr(ADDR_COMMAND, 24'h000001);
        wr(ADDR_COMMAND, 24'h000001);
        check(rd_w, WORD_ZERO);
        wr(ADDR_START_CNT, WORD_ZERO);
        check(rd_w, 24'h00ABCD);
        wr(8'h55, WORD_ZERO);
        check(rd_w, WORD_ZERO);
        $display("test readback done");
        for (int i = 0; i < 4; i++)
        begin
            d = {8'h00, 16'($urandom)};
            wr(ADDR_COMMAND, WORD_ZERO);
            wr(ADDR_START_CNT, d);
            wr(ADDR_COMMAND, 24'h000001);
            wr(ADDR_START_CNT, WORD_ZERO);
            check(rd_w, start_read(d));
        end
        $display("test start count done");
        fault_probe_in = 13'($urandom) | 13'h0001;
        wr(ADDR_COMMAND, WORD_ZERO);
        check({23'h000000, fault_check_active}, WORD_ZERO);
        act_len = 0;
        wr(ADDR_COMMAND, 24'h000004);
        wait_lvl(fault_check_active, 1'b0);
        check(24'(act_len), 24'(FAULT_FLAG_REGISTER_SIM));
        check({11'h000, fault_flag_register}, {11'h000, fault_probe_in});
        wr(ADDR_COMMAND, 24'h000001);
        wr(ADDR_FAULT_FLAG, WORD_ZERO);
        check(rd_w, {11'h000, fault_probe_in});
        $display("test diagnostics done");
        wr(ADDR_COMMAND, WORD_ZERO);
        wr(ADDR_START_CNT, 24'h00FFFF);
        wr(ADDR_COMMAND, 24'h00000F);
        check({23'h000000, fault_check_active}, WORD_ZERO);
        check({11'h000, fault_flag_register}, WORD_ZERO);
        wr(ADDR_COMMAND, 24'h000001);
        wr(ADDR_START_CNT, WORD_ZERO);
        check(rd_w, WORD_ZERO);
        $display("test soft reset done");
        d = 24'(1 + $urandom % 4);
        wr(ADDR_COMMAND, 24'h000002);
        wr(ADDR_START_CNT, d);
        ticks = 0;
        step(30);
        check({8'h00, period_count}, WORD_ZERO);
        check(24'(ticks), WORD_ZERO);
        wr(ADDR_COMMAND, WORD_ZERO);
        wait_lvl(timebase_tick, 1'b1);
        stamp = cycles;
        step(1);
        wait_lvl(timebase_tick, 1'b1);
        check(24'(cycles - stamp), 24'(CLK_HZ / TB_RATE_HZ));
        wait_lvl(sample_window, 1'b1);
        check({8'h00, period_count}, d);
        wait_lvl(sample_window, 1'b0);
        check({8'h00, period_count}, {8'h00, sample_end_count});
        $display("test timebase done");
        wrap_up();
    end
endmodule
